//--- verilog/gdf_pkg.sv
// Shared timing constants and state encoding for the gate driver fault/enable link
package gdf_pkg;
  localparam int unsigned GDF_CLK_PERIOD_NS = 10;
  localparam int unsigned GDF_DEGLITCH_NS   = 40;
  // Least time: round up so that anything shorter than the figure is rejected
  localparam int unsigned GDF_DEGLITCH_CYC  =
    (GDF_DEGLITCH_NS + GDF_CLK_PERIOD_NS - 1) / GDF_CLK_PERIOD_NS;
  // Mute and reset filter intervals carry no printed figure; plain defaults in cycles
  localparam int unsigned GDF_MUTE_CYC      = 64;
  localparam int unsigned GDF_RSTFIL_CYC    = 32;
  localparam int unsigned GDF_CNT_W         = 16;
  localparam logic        GDF_EN_RST_VAL    = 1'b0;
  localparam logic        GDF_PWM_RST_VAL   = 1'b0;

  typedef enum logic [2:0] {
    GDF_ST_RUN  = 3'b001,
    GDF_ST_MUTE = 3'b010,
    GDF_ST_FILT = 3'b100
  } gdf_state_t;

  typedef enum logic [1:0] {
    GDF_MODE_MANUAL   = 2'h0,
    GDF_MODE_AUTO_POS = 2'h1,
    GDF_MODE_AUTO_NEG = 2'h2
  } gdf_mode_t;
endpackage

//--- verilog/gdf_link_if.sv
// Pin-level link between host controller and gate driver, with wire resolution
`timescale 1ns/1ns
interface gdf_link_if;
  logic pwm_pos;
  logic pwm_neg;
  logic rst_en_o;
  logic rst_en_oe;
  logic rst_en;
  logic fault_flag_n_o;
  logic fault_flag_n_oe;
  logic fault_flag_n;
  logic supply_good_o;
  logic supply_good_oe;
  logic supply_good;

  // Internal pulldown: an undriven enable pin reads low
  assign rst_en       = rst_en_oe ? rst_en_o : 1'b0;
  // External pullups: open-drain lines read high unless pulled low
  assign fault_flag_n = fault_flag_n_oe ? fault_flag_n_o : 1'b1;
  assign supply_good  = supply_good_oe ? supply_good_o : 1'b1;

  modport dev (
    input  pwm_pos,
    input  pwm_neg,
    input  rst_en,
    output fault_flag_n_o,
    output fault_flag_n_oe,
    output supply_good_o,
    output supply_good_oe
  );

  modport host (
    output pwm_pos,
    output pwm_neg,
    output rst_en_o,
    output rst_en_oe,
    input  fault_flag_n,
    input  supply_good
  );
endinterface

//--- verilog/gdf_deglitch.sv
// Input deglitch filter: a level is passed only after it has held for CYC cycles
`timescale 1ns/1ns
module gdf_deglitch
  import gdf_pkg::*;
#(
  parameter int unsigned CYC     = GDF_DEGLITCH_CYC,
  parameter logic        RST_VAL = 1'b0
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic din,
  output logic      dout
);
  logic [GDF_CNT_W-1:0] cnt_ff;
  logic                 dout_ff;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt_ff  <= '0;
      dout_ff <= RST_VAL;
    end else if (din == dout_ff) begin
      cnt_ff  <= '0;
    end else if (cnt_ff == GDF_CNT_W'(CYC - 1)) begin
      cnt_ff  <= '0;
      dout_ff <= din;
    end else begin
      cnt_ff  <= cnt_ff + 1'b1;
    end
  end

  assign dout = dout_ff;
endmodule // gdf_deglitch

//--- verilog/gdf_device.sv
// Gate driver input-side control: enable, overcurrent latch, mute and reset filter
//
// What this block does
// - Fault and supply-good pins only pull low
// - Undriven enable pin reads low, driver off
// - Enable high runs driver; low holds gate off
// - Overcurrent latches fault flag and gate low
// - Host pulls enable low to clear fault
// - Enable ignored during fault mute interval
// - Reset needs low for filter time after mute
// - Auto-reset: same PWM on positive and enable
// - Auto-reset inverting: enable is PWM, negative input gets inverted PWM
// - Auto-reset PWM off-time exceeds filter time
// - Both PWM inputs high forces gate low
// - Reject pulses under 40ns on PWM and enable inputs
// - Undervoltage: gate low, supply-good pulled low
`timescale 1ns/1ns
module gdf_device
  import gdf_pkg::*;
#(
  parameter int unsigned MUTE_CYC   = GDF_MUTE_CYC,
  parameter int unsigned FILT_CYC   = GDF_RSTFIL_CYC,
  parameter int unsigned GLITCH_CYC = GDF_DEGLITCH_CYC
) (
  input  wire logic clock,
  input  wire logic nrst,
  gdf_link_if.dev   link,
  input  wire logic overcurrent_sense,
  input  wire logic supply_uv,
  output logic      gate_source_out,
  output logic      gate_sink_out,
  output logic      fault_latched
);
  localparam int NIN = 3;

  logic [NIN-1:0]       raw_in;
  logic [NIN-1:0]       flt_in;
  logic                 pos_f;
  logic                 neg_f;
  logic                 en_f;
  gdf_state_t           state_ff;
  gdf_state_t           nxt_state;
  logic [GDF_CNT_W-1:0] cnt_ff;
  logic [GDF_CNT_W-1:0] nxt_cnt;
  logic                 nxt_gate;
  logic                 gate_src_ff;
  logic                 gate_snk_ff;
  logic                 fault_oe_ff;
  logic                 ready_oe_ff;
  logic                 fault_lat_ff;

  function automatic logic [NIN-1:0] glitch_rst_val();
    glitch_rst_val = {GDF_EN_RST_VAL, GDF_PWM_RST_VAL, GDF_PWM_RST_VAL};
  endfunction

  // Held as a constant so each filter can take its own bit as a parameter
  localparam logic [NIN-1:0] GLITCH_RST = glitch_rst_val();

  assign raw_in = {link.rst_en, link.pwm_neg, link.pwm_pos};

  // One filter per input pin; all three share the same rejection width
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_glitch
      gdf_deglitch #(
        .CYC     (GLITCH_CYC),
        .RST_VAL (GLITCH_RST[gi])
      ) u_glitch (
        .clock (clock),
        .nrst  (nrst),
        .din   (raw_in[gi]),
        .dout  (flt_in[gi])
      );
    end
  endgenerate

  assign pos_f = flt_in[0];
  assign neg_f = flt_in[1];
  assign en_f  = flt_in[2];

  // Fault sequencer: latch, mute, then wait for a long enough low on enable
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      GDF_ST_RUN: begin
        nxt_cnt = '0;
        if (overcurrent_sense) begin
          nxt_state = GDF_ST_MUTE;
        end
      end
      GDF_ST_MUTE: begin
        // Enable is not looked at here at all
        if (cnt_ff == GDF_CNT_W'(MUTE_CYC - 1)) begin
          nxt_state = GDF_ST_FILT;
          nxt_cnt   = '0;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      GDF_ST_FILT: begin
        // A high before the filter time expires restarts the count
        if (en_f) begin
          nxt_cnt = '0;
        end else if (cnt_ff == GDF_CNT_W'(FILT_CYC - 1)) begin
          nxt_state = GDF_ST_RUN;
          nxt_cnt   = '0;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      default: begin
        nxt_state = GDF_ST_MUTE;
        nxt_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_ff <= GDF_ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Gate is on only with enable high, no fault, no undervoltage and no interlock
  always_comb begin
    nxt_gate = 1'b1;
    if (!en_f) begin
      nxt_gate = 1'b0;
    end
    if (pos_f && neg_f) begin
      nxt_gate = 1'b0;
    end
    if (!pos_f) begin
      nxt_gate = 1'b0;
    end
    if (supply_uv) begin
      nxt_gate = 1'b0;
    end
    if (nxt_state != GDF_ST_RUN || state_ff != GDF_ST_RUN) begin
      nxt_gate = 1'b0;
    end
  end

  // Split outputs: source and sink never on together, sink holds the gate at reset
  always_ff @(posedge clock) begin
    if (!nrst) begin
      gate_src_ff <= 1'b0;
    end else begin
      gate_src_ff <= nxt_gate;
    end
  end

  // Both halves come from one next value, so no overlap can arise between them
  always_ff @(posedge clock) begin
    if (!nrst) begin
      gate_snk_ff <= 1'b1;
    end else begin
      gate_snk_ff <= !nxt_gate;
    end
  end

  // Fault flag pulls low from the latching edge until the filter completes
  always_ff @(posedge clock) begin
    if (!nrst) begin
      fault_oe_ff <= 1'b0;
    end else begin
      fault_oe_ff <= (nxt_state != GDF_ST_RUN);
    end
  end

  // Status copy kept apart from the pin so that both stay registered outputs
  always_ff @(posedge clock) begin
    if (!nrst) begin
      fault_lat_ff <= 1'b0;
    end else begin
      fault_lat_ff <= (nxt_state != GDF_ST_RUN);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ready_oe_ff <= 1'b0;
    end else begin
      ready_oe_ff <= supply_uv;
    end
  end

  // Open drain: the data line is fixed low, only the enable moves
  assign link.fault_flag_n_o  = 1'b0;
  assign link.fault_flag_n_oe = fault_oe_ff;
  assign link.supply_good_o   = 1'b0;
  assign link.supply_good_oe  = ready_oe_ff;

  assign gate_source_out = gate_src_ff;
  assign gate_sink_out   = gate_snk_ff;
  assign fault_latched   = fault_lat_ff;
endmodule // gdf_device

//--- verilog/gdf_host.sv
// Host controller end: drives PWM and enable, issues fault resets or auto-reset
`timescale 1ns/1ns
module gdf_host
  import gdf_pkg::*;
#(
  parameter int unsigned MUTE_CYC   = GDF_MUTE_CYC,
  parameter int unsigned FILT_CYC   = GDF_RSTFIL_CYC,
  parameter int unsigned GLITCH_CYC = GDF_DEGLITCH_CYC
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  gdf_link_if.host        link,
  input  wire logic       pwm_cmd,
  input  wire logic       interlock_in,
  input  wire logic [1:0] mode,
  input  wire logic       enable_cmd,
  input  wire logic       reset_req,
  output logic            fault_seen,
  output logic            supply_good_seen,
  output logic            reset_busy
);
  // Manual reset low covers mute, filter and both filter latencies with margin
  localparam int unsigned HOLD_CYC    = MUTE_CYC + FILT_CYC + 2 * GLITCH_CYC + 2;
  localparam int unsigned MIN_OFF_CYC = FILT_CYC + 1;

  logic [GDF_CNT_W-1:0] off_cnt_ff;
  logic [GDF_CNT_W-1:0] hold_cnt_ff;
  logic                 on_ff;
  logic                 busy_ff;
  logic                 pos_ff;
  logic                 neg_ff;
  logic                 en_o_ff;
  logic                 en_oe_ff;
  logic                 fault_ff;
  logic                 good_ff;
  logic                 nxt_pos;
  logic                 nxt_neg;
  logic                 nxt_en;

  // Off-time stretch: a new on-phase waits until the low has lasted past the filter
  always_ff @(posedge clock) begin
    if (!nrst) begin
      off_cnt_ff <= '0;
      on_ff      <= 1'b0;
    end else if (on_ff) begin
      on_ff      <= pwm_cmd;
      off_cnt_ff <= '0;
    end else begin
      if (off_cnt_ff != GDF_CNT_W'(MIN_OFF_CYC)) begin
        off_cnt_ff <= off_cnt_ff + 1'b1;
      end
      on_ff <= pwm_cmd && (off_cnt_ff == GDF_CNT_W'(MIN_OFF_CYC));
    end
  end

  // Manual reset: hold enable low long enough after a seen fault
  always_ff @(posedge clock) begin
    if (!nrst) begin
      busy_ff     <= 1'b0;
      hold_cnt_ff <= '0;
    end else if (busy_ff) begin
      if (hold_cnt_ff == GDF_CNT_W'(HOLD_CYC - 1)) begin
        busy_ff <= 1'b0;
      end
      hold_cnt_ff <= hold_cnt_ff + 1'b1;
    end else if (reset_req && fault_ff && mode == GDF_MODE_MANUAL) begin
      busy_ff     <= 1'b1;
      hold_cnt_ff <= '0;
    end
  end

  always_comb begin
    nxt_pos = pwm_cmd;
    nxt_neg = interlock_in;
    nxt_en  = enable_cmd && !busy_ff;
    case (mode)
      GDF_MODE_MANUAL: begin
        nxt_pos = pwm_cmd;
      end
      GDF_MODE_AUTO_POS: begin
        nxt_pos = on_ff;
        nxt_en  = on_ff;
      end
      GDF_MODE_AUTO_NEG: begin
        nxt_pos = 1'b1;
        nxt_neg = !on_ff;
        nxt_en  = on_ff;
      end
      default: begin
        nxt_pos = 1'b0;
        nxt_neg = 1'b0;
        nxt_en  = 1'b0;
      end
    endcase
  end

  // Enable pin left undriven through reset so the pulldown keeps the driver off
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pos_ff   <= 1'b0;
      neg_ff   <= 1'b0;
      en_o_ff  <= 1'b0;
      en_oe_ff <= 1'b0;
    end else begin
      pos_ff   <= nxt_pos;
      neg_ff   <= nxt_neg;
      en_o_ff  <= nxt_en;
      en_oe_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      fault_ff <= 1'b0;
      good_ff  <= 1'b0;
    end else begin
      fault_ff <= !link.fault_flag_n;
      good_ff  <= link.supply_good;
    end
  end

  assign link.pwm_pos   = pos_ff;
  assign link.pwm_neg   = neg_ff;
  assign link.rst_en_o  = en_o_ff;
  assign link.rst_en_oe = en_oe_ff;

  assign fault_seen       = fault_ff;
  assign supply_good_seen = good_ff;
  assign reset_busy       = busy_ff;
endmodule // gdf_host

//--- sim/gdf_chk.sv
// Assertions on the pin link and gate outputs of the gate driver pair
`timescale 1ns/1ns
module gdf_chk
  import gdf_pkg::*;
#(
  parameter int unsigned MUTE_CYC = GDF_MUTE_CYC,
  parameter int unsigned FILT_CYC = GDF_RSTFIL_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic pwm_pos,
  input wire logic pwm_neg,
  input wire logic rst_en,
  input wire logic fault_flag_n_o,
  input wire logic fault_flag_n_oe,
  input wire logic supply_good_o,
  input wire logic supply_good_oe,
  input wire logic overcurrent_sense,
  input wire logic supply_uv,
  input wire logic gate_source_out,
  input wire logic gate_sink_out,
  input wire logic fault_latched
);
  logic [15:0] hold_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // Cycles the fault pin has been pulled low so far
  always_ff @(posedge clock) begin
    if (!nrst || !fault_flag_n_oe) begin
      hold_ff <= 16'h0;
    end else begin
      hold_ff <= hold_ff + 16'h1;
    end
  end

  // Four filter edges plus the registered gate stage
  sequence s_en_low;
    !rst_en [*5];
  endsequence
  sequence s_both_on;
    (pwm_pos && pwm_neg) [*5];
  endsequence

  a_flag_drain:
    assert property (fault_flag_n_oe |-> !fault_flag_n_o) else $error("fault pin driven high");
  a_good_drain:
    assert property (supply_good_oe |-> !supply_good_o) else $error("ready pin driven high");
  a_sink_split:
    assert property (gate_sink_out == !gate_source_out) else $error("gate halves overlap");
  a_en_low_off:
    assert property (s_en_low |=> !gate_source_out) else $error("gate on while disabled");
  a_oc_latch:
    assert property (overcurrent_sense && !fault_latched |=>
      fault_flag_n_oe && fault_latched && !gate_source_out) else $error("fault not latched");
  a_latch_gate:
    assert property (fault_latched |-> !gate_source_out) else $error("gate on during fault");
  a_mute_filter:
    assert property ($fell(fault_flag_n_oe) |-> hold_ff >= MUTE_CYC + FILT_CYC
      && !$past(rst_en, 1) && !$past(rst_en, 2)) else $error("fault released early");
  a_interlock:
    assert property (s_both_on |=> !gate_source_out) else $error("interlock failed");
  a_uv_off:
    assert property (supply_uv |=> supply_good_oe && !gate_source_out) else $error("uv ignored");
  a_uv_back:
    assert property ($fell(supply_uv) |=> !supply_good_oe) else $error("ready not restored");
  a_glitch_block:
    assert property ($rose(gate_source_out) |-> $past(pwm_pos, 2) && $past(pwm_pos, 3)
      && $past(pwm_pos, 4) && $past(pwm_pos, 5)) else $error("short pulse passed");
endmodule // gdf_chk

//--- sim/tb_top.sv
// Self-checking bench joining host and device ends over the pin link
`timescale 1ns/1ns
module tb_top;
  import gdf_pkg::*;
  // Short mute and filter counts keep the run brief
  localparam int unsigned MUTE = 16;
  localparam int unsigned FILT = 4;
  logic       clock = 1'b0;
  logic       nrst = 1'b0;
  logic       overcurrent_sense = 1'b0;
  logic       supply_uv = 1'b0;
  logic       pwm_cmd = 1'b0;
  logic       interlock_in = 1'b0;
  logic [1:0] mode = 2'h0;
  logic       enable_cmd = 1'b0;
  logic       reset_req = 1'b0;
  logic       gate_source_out;
  logic       gate_sink_out;
  logic       fault_latched;
  logic       fault_seen;
  logic       supply_good_seen;
  logic       reset_busy;
  int         n_errors = 0;
  int         tests_run = 0;
  int         cyc = 0;

  gdf_link_if link ();
  always #5 clock = ~clock;

  gdf_device #(.MUTE_CYC(MUTE), .FILT_CYC(FILT)) gdf_device_i (.clock(clock), .nrst(nrst),
    .link(link), .overcurrent_sense(overcurrent_sense), .supply_uv(supply_uv),
    .gate_source_out(gate_source_out), .gate_sink_out(gate_sink_out),
    .fault_latched(fault_latched));
  gdf_host #(.MUTE_CYC(MUTE), .FILT_CYC(FILT)) gdf_host_i (.clock(clock), .nrst(nrst),
    .link(link), .pwm_cmd(pwm_cmd), .interlock_in(interlock_in), .mode(mode),
    .enable_cmd(enable_cmd), .reset_req(reset_req), .fault_seen(fault_seen),
    .supply_good_seen(supply_good_seen), .reset_busy(reset_busy));
  gdf_chk #(.MUTE_CYC(MUTE), .FILT_CYC(FILT)) gdf_chk_i (.clock(clock), .nrst(nrst),
    .pwm_pos(link.pwm_pos), .pwm_neg(link.pwm_neg), .rst_en(link.rst_en),
    .fault_flag_n_o(link.fault_flag_n_o), .fault_flag_n_oe(link.fault_flag_n_oe),
    .supply_good_o(link.supply_good_o), .supply_good_oe(link.supply_good_oe),
    .overcurrent_sense(overcurrent_sense), .supply_uv(supply_uv),
    .gate_source_out(gate_source_out), .gate_sink_out(gate_sink_out),
    .fault_latched(fault_latched));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic drv(input logic p, input logic e, input logic il, input logic [1:0] m);
    @(posedge clock);
    pwm_cmd <= p;
    enable_cmd <= e;
    interlock_in <= il;
    mode <= m;
  endtask

  function automatic logic pick(input int w);
    return w == 0 ? gate_source_out : (w == 1 ? link.fault_flag_n :
      (w == 2 ? link.supply_good : link.rst_en));
  endfunction

  // Bounded wait so a stuck design reports instead of hanging
  task automatic wait_for(input int w, input logic exp, input int lim, input string what);
    int i;
    i = 0;
    while (pick(w) !== exp && i < lim) begin
      @(posedge clock);
      #1;
      i++;
    end
    chk(pick(w), exp, what);
  endtask

  task automatic hold(input int w, input logic exp, input int n, input string what);
    repeat (n) begin
      @(posedge clock);
      #1;
      chk(pick(w), exp, what);
    end
  endtask

  task automatic oc_pulse();
    @(posedge clock);
    overcurrent_sense <= 1'b1;
    @(posedge clock);
    overcurrent_sense <= 1'b0;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      wrap_up();
    end
  end

  initial begin
    repeat (16) @(posedge clock);
    chk(link.rst_en, 1'b0, "enable pin idle");
    chk(gate_source_out, 1'b0, "gate off in reset");
    nrst <= 1'b1;
    drv(1'b1, 1'b1, 1'b0, 2'h0);
    wait_for(0, 1'b1, 20, "gate on");
    chk(gate_sink_out, 1'b0, "sink off");
    drv(1'b1, 1'b0, 1'b0, 2'h0);
    wait_for(0, 1'b0, 20, "gate off");
    drv(1'b0, 1'b1, 1'b0, 2'h0);
    repeat (9) @(posedge clock);
    // Three-cycle pulse stays under the deglitch window
    drv(1'b1, 1'b1, 1'b0, 2'h0);
    drv(1'b1, 1'b1, 1'b0, 2'h0);
    drv(1'b1, 1'b1, 1'b0, 2'h0);
    drv(1'b0, 1'b1, 1'b0, 2'h0);
    hold(0, 1'b0, 10, "pulse rejected");
    drv(1'b1, 1'b1, 1'b0, 2'h0);
    wait_for(0, 1'b1, 20, "gate on");
    drv(1'b1, 1'b1, 1'b1, 2'h0);
    wait_for(0, 1'b0, 20, "interlock");
    drv(1'b1, 1'b1, 1'b0, 2'h0);
    wait_for(0, 1'b1, 20, "gate on");
    $display("test basic done");
    @(posedge clock);
    supply_uv <= 1'b1;
    wait_for(2, 1'b0, 10, "ready low");
    wait_for(0, 1'b0, 10, "gate off uv");
    hold(2, 1'b0, 2, "ready held low");
    chk(supply_good_seen, 1'b0, "host saw ready low");
    @(posedge clock);
    supply_uv <= 1'b0;
    wait_for(2, 1'b1, 10, "ready back");
    wait_for(0, 1'b1, 20, "gate back");
    $display("test uv done");
    oc_pulse();
    wait_for(1, 1'b0, 5, "fault flag");
    chk(gate_source_out, 1'b0, "gate latched off");
    chk(fault_seen, 1'b1, "host saw fault");
    // Low enable inside the mute window must not clear the fault
    drv(1'b1, 1'b0, 1'b0, 2'h0);
    repeat (5) @(posedge clock);
    drv(1'b1, 1'b1, 1'b0, 2'h0);
    hold(1, 1'b0, 40, "fault held");
    @(posedge clock);
    reset_req <= 1'b1;
    @(posedge clock);
    reset_req <= 1'b0;
    hold(1, 1'b0, 4, "reset filtered");
    chk(reset_busy, 1'b1, "host holds reset");
    wait_for(1, 1'b1, 60, "fault cleared");
    wait_for(0, 1'b1, 60, "gate resumes");
    chk(reset_busy, 1'b0, "host reset done");
    $display("test manual fault done");
    for (int m = 1; m < 3; m++) begin
      drv(1'b0, 1'b0, 1'b0, 2'(m));
      repeat (10) @(posedge clock);
      drv(1'b1, 1'b0, 1'b0, 2'(m));
      wait_for(0, 1'b1, 40, "auto on");
      chk(link.rst_en, 1'b1, "enable follows on");
      chk(m == 1 ? link.pwm_pos : ~link.pwm_neg, 1'b1, "pwm on");
      oc_pulse();
      wait_for(1, 1'b0, 5, "auto fault");
      drv(1'b0, 1'b0, 1'b0, 2'(m));
      repeat (4) @(posedge clock);
      chk(link.rst_en, 1'b0, "enable follows off");
      chk(m == 1 ? link.pwm_pos : ~link.pwm_neg, 1'b0, "pwm off");
      wait_for(1, 1'b1, 60, "auto cleared");
      drv(1'b1, 1'b0, 1'b0, 2'(m));
      wait_for(0, 1'b1, 40, "auto resumes");
      // One-cycle off request must be stretched past the reset filter time
      drv(1'b0, 1'b0, 1'b0, 2'(m));
      drv(1'b1, 1'b0, 1'b0, 2'(m));
      hold(3, 1'b0, FILT + 1, "off-time stretched");
      wait_for(0, 1'b1, 40, "auto back on");
      $display("test auto mode %0d done", m);
    end
    drv(1'b1, 1'b1, 1'b0, 2'h3);
    wait_for(0, 1'b0, 20, "parked off");
    chk(link.rst_en, 1'b0, "parked enable low");
    $display("test mode off done");
    wrap_up();
  end
endmodule // tb_top
